// *** design/icm_defines.svh ***
// offsets, field positions, reset values and timing counts of the interval counter bank
`ifndef ICM_DEFINES_SVH
`define ICM_DEFINES_SVH

`define ICM_ADDR_CNT0       4'h0
`define ICM_ADDR_CNT1       4'h1
`define ICM_ADDR_CNT2       4'h2
`define ICM_ADDR_MODE       4'h3
`define ICM_ADDR_GATE_CLK   4'hF

`define ICM_MODE_IDX_MSB    7
`define ICM_MODE_IDX_LSB    6
`define ICM_MODE_VAL_MSB    2
`define ICM_MODE_VAL_LSB    0

`define ICM_TRIG_GATE_BIT   0
`define ICM_CLK_SEL_BIT     1
`define ICM_SEL_RESET       2'h0
`define ICM_COUNT_RESET     16'h0000
`define ICM_HALF_FULL       16'h8000

`define ICM_SYS_PERIOD_NS   40
`define ICM_INT_PERIOD_NS   10000
`define ICM_INT_HALF_CYC    ((`ICM_INT_PERIOD_NS / 2) / `ICM_SYS_PERIOD_NS)

`endif

// *** design/icm_pkg.sv ***
// types of the interval counter bank
package icm_pkg;

  typedef enum logic [2:0] {
    MODE_IDLE      = 3'b000,
    MODE_RATE      = 3'b010,
    MODE_SQUARE    = 3'b011,
    MODE_SW_STROBE = 3'b100,
    MODE_HW_STROBE = 3'b101
  } icm_mode_type;

  typedef struct packed {
    icm_mode_type mode;
    logic [15:0]  init;
    logic [15:0]  cnt;
    logic         clk_prev;
    logic         gate_prev;
    logic         load_pend;
    logic         run;
    logic         armed;
    logic         out;
  } icm_ctr_type;

  typedef struct packed {
    logic [1:0]        sel;
    icm_ctr_type [2:0] ctr;
    logic [15:0]       rdata;
  } icm_top_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic       lvl;
  } icm_pre_type;

endpackage

// *** design/icm_prescale.sv ***
// internal system-clock-derived 100 kHz clock level for the first counter
`timescale 1ns/1ps
`include "icm_defines.svh"
module icm_prescale #(
  parameter logic [7:0] HALF_CYC = 8'(`ICM_INT_HALF_CYC)
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // divided level
  output logic      o_clk_lvl
);

  icm_pkg::icm_pre_type st_r;
  icm_pkg::icm_pre_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt == HALF_CYC - 8'h01) begin
      st_nxt.cnt = 8'h00;
      st_nxt.lvl = ~st_r.lvl;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_clk_lvl = st_r.lvl;

endmodule // icm_prescale

// *** design/icm_timer.sv ***
// three cascadable 16-bit down counters with gate and clock control
//
// Operation
// - rate mode: output high, one-clock low pulse at count one, reload, repeat.
// - rate mode: low gate stops counting; gate low forces pulse output high.
// - rate mode: new count waits for reload; software never programs one.
// - square mode: high first half, low second half, reload and repeat.
// - odd count n: high (n+1)/2 counts, low (n-1)/2 counts.
// - square mode: low gate halts counting and forces output high at once.
// - software strobe: load next clock, count after, low pulse n+1 after write.
// - software strobe: gate only enables counting, never touches output.
// - hardware strobe: gate rise loads next clock, pulse n+1 clocks later.
// - hardware strobe: new count leaves running sequence alone; a gate rise retriggers it.
// - two-bit write-only gate and clock control register at offset F.
// - low control bit lets the trigger input gate the cascaded pair.
// - second control bit picks external pin or internal 100 kHz clock.
// - first counter square wave divides by 2 up to 65,536.
// - pulse width: load full count with gate low, count while high.
// - a counter clock pulse is a falling then a rising edge.
// - second counter runs from the crystal, its output clocks the third.
// - each counter is a presettable 16-bit divider from 2 to 65,536.
`timescale 1ns/1ps
`include "icm_defines.svh"
module icm_timer #(
  parameter logic [7:0] INT_HALF_CYC = 8'(`ICM_INT_HALF_CYC)
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // host register port
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata,
  // counter pins
  input  wire logic        i_ctr0_clk,
  input  wire logic        i_first_counter_gate_input,
  input  wire logic        i_external_trigger_input,
  input  wire logic        i_xtal_clk,
  // counter outputs
  output logic             o_ctr0_out,
  output logic             o_ctr1_out,
  output logic             o_ctr2_out
);

  localparam icm_pkg::icm_ctr_type CTR_RST = '{
    mode:      icm_pkg::MODE_IDLE,
    init:      `ICM_COUNT_RESET,
    cnt:       `ICM_COUNT_RESET,
    clk_prev:  1'b1,
    gate_prev: 1'b1,
    load_pend: 1'b0,
    run:       1'b0,
    armed:     1'b0,
    out:       1'b1
  };

  icm_pkg::icm_top_type st_r;
  icm_pkg::icm_top_type st_nxt;

  logic       int_clk;
  logic [2:0] ctr_clk;
  logic [2:0] ctr_gate;
  logic [2:0] wr_cnt;
  logic [2:0] wr_mode;
  logic       gate_pair;

  icm_prescale #(
    .HALF_CYC (INT_HALF_CYC)
  ) u_prescale (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .o_clk_lvl (int_clk)
  );

  // unknown mode codes leave the counter idle with its output high
  function automatic icm_pkg::icm_mode_type decode_mode(input logic [2:0] code);
    icm_pkg::icm_mode_type m;
    case (code)
      3'h2:    m = icm_pkg::MODE_RATE;
      3'h3:    m = icm_pkg::MODE_SQUARE;
      3'h4:    m = icm_pkg::MODE_SW_STROBE;
      3'h5:    m = icm_pkg::MODE_HW_STROBE;
      default: m = icm_pkg::MODE_IDLE;
    endcase
    return m;
  endfunction

  // a loaded zero stands for 65,536, whose half is 32,768
  function automatic logic [15:0] half_of(input logic [15:0] n);
    return (n == 16'h0000) ? `ICM_HALF_FULL : (n >> 1);
  endfunction

  function automatic logic clk_pulse(input icm_pkg::icm_ctr_type s, input logic clk_in);
    return clk_in & ~s.clk_prev;
  endfunction

  function automatic icm_pkg::icm_ctr_type ctr_step(
    input icm_pkg::icm_ctr_type s,
    input logic                 clk_in,
    input logic                 gate,
    input logic                 wr_c,
    input logic                 wr_m,
    input logic [15:0]          wdata
  );
    icm_pkg::icm_ctr_type n;
    logic                 pulse;
    logic                 rise;
    logic [15:0]          dec;
    n         = s;
    pulse     = clk_pulse(s, clk_in);
    rise      = gate & ~s.gate_prev;
    dec       = s.cnt - 16'h0001;
    n.clk_prev  = clk_in;
    n.gate_prev = gate;
    if (wr_m) begin
      n.mode      = decode_mode(wdata[`ICM_MODE_VAL_MSB:`ICM_MODE_VAL_LSB]);
      n.out       = 1'b1;
      n.load_pend = 1'b0;
      n.run       = 1'b0;
      n.armed     = 1'b0;
    end else begin
      if (pulse) begin
        case (s.mode)
          icm_pkg::MODE_RATE: begin
            if (s.load_pend) begin
              n.cnt       = s.init;
              n.load_pend = 1'b0;
              n.run       = 1'b1;
              n.out       = 1'b1;
            end else if (gate && s.run) begin
              if (s.cnt == 16'h0001) begin
                n.cnt = s.init;
                n.out = 1'b1;
              end else begin
                n.cnt = dec;
                n.out = (dec != 16'h0001);
              end
            end
          end
          icm_pkg::MODE_SQUARE: begin
            if (s.load_pend) begin
              n.cnt       = s.init;
              n.load_pend = 1'b0;
              n.run       = 1'b1;
              n.out       = 1'b1;
            end else if (gate && s.run) begin
              if (s.cnt == 16'h0001) begin
                n.cnt = s.init;
                n.out = 1'b1;
              end else begin
                n.cnt = dec;
                if (dec == half_of(s.init)) begin
                  n.out = 1'b0;
                end
              end
            end
          end
          icm_pkg::MODE_SW_STROBE: begin
            n.out = 1'b1;
            if (s.load_pend) begin
              n.cnt       = s.init;
              n.load_pend = 1'b0;
              n.armed     = 1'b1;
            end else if (gate) begin
              n.cnt = dec;
              if (s.armed && dec == 16'h0000) begin
                n.out   = 1'b0;
                n.armed = 1'b0;
              end
            end
          end
          icm_pkg::MODE_HW_STROBE: begin
            n.out = 1'b1;
            if (s.load_pend) begin
              n.cnt       = s.init;
              n.load_pend = 1'b0;
              n.armed     = 1'b1;
            end else begin
              // once triggered the gate level no longer matters
              n.cnt = dec;
              if (s.armed && dec == 16'h0000) begin
                n.out   = 1'b0;
                n.armed = 1'b0;
              end
            end
          end
          default: begin
            n.out = 1'b1;
          end
        endcase
      end
      // requests are raised after the clock step so one landing in the load cycle is kept
      if (wr_c) begin
        // a running rate or square sequence picks the new count up at reload
        n.init = wdata;
        if (s.mode == icm_pkg::MODE_SW_STROBE) begin
          n.load_pend = 1'b1;
        end else if ((s.mode == icm_pkg::MODE_RATE || s.mode == icm_pkg::MODE_SQUARE)
                     && !s.run) begin
          n.load_pend = 1'b1;
        end
      end
      if (rise && s.mode == icm_pkg::MODE_HW_STROBE) begin
        n.load_pend = 1'b1;
      end
      if (rise && s.run && (s.mode == icm_pkg::MODE_RATE || s.mode == icm_pkg::MODE_SQUARE)) begin
        n.load_pend = 1'b1;
      end
      // the gate drop forces the output high at once, not on the next counter clock
      if (!gate && (s.mode == icm_pkg::MODE_RATE || s.mode == icm_pkg::MODE_SQUARE)) begin
        n.out = 1'b1;
      end
    end
    return n;
  endfunction

  always_comb begin
    gate_pair   = st_r.sel[`ICM_TRIG_GATE_BIT] ? i_external_trigger_input : 1'b1;
    ctr_clk[0]  = st_r.sel[`ICM_CLK_SEL_BIT] ? int_clk : i_ctr0_clk;
    ctr_clk[1]  = i_xtal_clk;
    ctr_clk[2]  = st_r.ctr[1].out;
    ctr_gate[0] = i_first_counter_gate_input;
    ctr_gate[1] = gate_pair;
    ctr_gate[2] = gate_pair;
    for (int i = 0; i < 3; i++) begin
      wr_cnt[i]  = i_wr && (i_addr == 4'(i));
      wr_mode[i] = i_wr && (i_addr == `ICM_ADDR_MODE)
                   && (i_wdata[`ICM_MODE_IDX_MSB:`ICM_MODE_IDX_LSB] == 2'(i));
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (i_wr && i_addr == `ICM_ADDR_GATE_CLK) begin
      st_nxt.sel = i_wdata[1:0];
    end
    for (int i = 0; i < 3; i++) begin
      st_nxt.ctr[i] = ctr_step(st_r.ctr[i], ctr_clk[i], ctr_gate[i],
                               wr_cnt[i], wr_mode[i], i_wdata);
    end
    // the control register is write-only and reads as zero
    if (i_rd) begin
      case (i_addr)
        `ICM_ADDR_CNT0: st_nxt.rdata = st_r.ctr[0].cnt;
        `ICM_ADDR_CNT1: st_nxt.rdata = st_r.ctr[1].cnt;
        `ICM_ADDR_CNT2: st_nxt.rdata = st_r.ctr[2].cnt;
        default:        st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r.sel   <= `ICM_SEL_RESET;
      st_r.ctr   <= {CTR_RST, CTR_RST, CTR_RST};
      st_r.rdata <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata    = st_r.rdata;
  assign o_ctr0_out = st_r.ctr[0].out;
  assign o_ctr1_out = st_r.ctr[1].out;
  assign o_ctr2_out = st_r.ctr[2].out;

  // checks on counter 0, the control register, the pair gate and the cascade
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  logic  c0_pulse;
  logic  c0_quiet;
  assign c0_pulse = clk_pulse(st_r.ctr[0], ctr_clk[0]);
  assign c0_quiet = !wr_cnt[0] && !wr_mode[0];

  sequence s_rate_last;
    st_r.ctr[0].mode == icm_pkg::MODE_RATE && c0_pulse && ctr_gate[0] && c0_quiet
    && st_r.ctr[0].run && !st_r.ctr[0].load_pend && st_r.ctr[0].cnt == 16'h0002;
  endsequence

  sequence s_rate_pulse_low;
    !o_ctr0_out && st_r.ctr[0].cnt == 16'h0001;
  endsequence

  AST_RATE_PULSE: assert property (s_rate_last |=> s_rate_pulse_low)
    else $error("rate mode did not pulse low at count one");

  AST_RATE_RELOAD: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_RATE && c0_pulse && ctr_gate[0] && c0_quiet
    && st_r.ctr[0].run && !st_r.ctr[0].load_pend && st_r.ctr[0].cnt == 16'h0001
    |=> o_ctr0_out && st_r.ctr[0].cnt == $past(st_r.ctr[0].init))
    else $error("rate mode did not reload and return high");

  AST_RATE_GATE_HIGH: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_RATE && !ctr_gate[0] && c0_quiet
    |=> o_ctr0_out && st_r.ctr[0].cnt == $past(st_r.ctr[0].cnt))
    else $error("rate mode output or count moved with gate low");

  AST_RATE_NEW_COUNT: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_RATE && st_r.ctr[0].run && wr_cnt[0] && !c0_pulse
    |=> st_r.ctr[0].cnt == $past(st_r.ctr[0].cnt) && !st_r.ctr[0].load_pend)
    else $error("count write disturbed a running rate sequence");

  AST_SQ_HALF: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_SQUARE && c0_pulse && ctr_gate[0] && c0_quiet
    && st_r.ctr[0].run && !st_r.ctr[0].load_pend && st_r.ctr[0].cnt != 16'h0001
    && st_r.ctr[0].cnt - 16'h0001 == half_of(st_r.ctr[0].init)
    |=> !o_ctr0_out)
    else $error("square wave did not go low at the half count");

  AST_SQ_GATE: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_SQUARE && !o_ctr0_out && !ctr_gate[0] && c0_quiet
    |=> o_ctr0_out)
    else $error("square wave not forced high by a low gate");

  sequence s_sw_load;
    st_r.ctr[0].mode == icm_pkg::MODE_SW_STROBE && c0_pulse && c0_quiet
    && st_r.ctr[0].load_pend;
  endsequence

  AST_SW_LOAD: assert property (
    s_sw_load |=> st_r.ctr[0].cnt == $past(st_r.ctr[0].init) && st_r.ctr[0].armed
    && o_ctr0_out)
    else $error("software strobe did not load on the next clock");

  AST_SW_GATE_NO_OUT: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_SW_STROBE && !c0_pulse && c0_quiet
    |=> $stable(o_ctr0_out))
    else $error("gate changed software strobe output");

  AST_HW_TRIGGER: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_HW_STROBE && !wr_mode[0]
    && ctr_gate[0] && !st_r.ctr[0].gate_prev && !c0_pulse
    |=> st_r.ctr[0].load_pend)
    else $error("gate rise did not arm a hardware strobe load");

  AST_HW_COUNT_ON: assert property (
    st_r.ctr[0].mode == icm_pkg::MODE_HW_STROBE && c0_pulse && c0_quiet
    && !st_r.ctr[0].load_pend && !ctr_gate[0]
    |=> st_r.ctr[0].cnt == $past(st_r.ctr[0].cnt) - 16'h0001)
    else $error("hardware strobe stopped counting on a low gate");

  AST_CTRL_WRITE: assert property (
    i_wr && i_addr == `ICM_ADDR_GATE_CLK
    |=> st_r.sel == $past(i_wdata[1:0]))
    else $error("control register not written");

  AST_PAIR_GATE: assert property (
    !st_r.sel[`ICM_TRIG_GATE_BIT] |-> ctr_gate[1] && ctr_gate[2])
    else $error("trigger input gated the pair while disabled");

  AST_CLK_SELECT: assert property (
    ctr_clk[0] == (st_r.sel[`ICM_CLK_SEL_BIT] ? int_clk : i_ctr0_clk))
    else $error("first counter clock source wrong");

  AST_CASCADE: assert property (
    $rose(st_r.ctr[1].out) && st_r.ctr[2].mode == icm_pkg::MODE_SW_STROBE
    && !wr_cnt[2] && !wr_mode[2] && st_r.ctr[2].load_pend
    |=> !st_r.ctr[2].load_pend)
    else $error("third counter not clocked by the second output");

endmodule // icm_timer

// *** verification/icm_pin_src.sv ***
// behavioural sources for the counter clock pins of the interval counter bank
`timescale 1ns/1ps
module icm_pin_src #(
  parameter int HALF = 4
) (
  // system clock
  input  wire logic i_clk,
  // run enable of the external counter clock
  input  wire logic i_run0,
  // clock levels
  output logic      o_ctr0_clk,
  output logic      o_xtal_clk
);
  int ph0 = 0;
  int ph1 = 0;

  initial begin
    o_ctr0_clk = 1'b1;
    o_xtal_clk = 1'b1;
  end

  // each level lasts HALF system cycles: a pulse is a fall then a rise
  // the pin clock stands still when stopped; the crystal runs free
  always @(posedge i_clk) begin
    #1;
    if (i_run0) begin
      ph0++;
      if (ph0 == HALF) begin
        ph0 = 0;
        o_ctr0_clk = ~o_ctr0_clk;
      end
    end
    ph1++;
    if (ph1 == HALF) begin
      ph1 = 0;
      o_xtal_clk = ~o_xtal_clk;
    end
  end
endmodule // icm_pin_src

// *** verification/icm_timer_tb.sv ***
// self-checking bench of the interval counter bank
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, ac); end end
module icm_timer_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        gate = 1'b1;
  logic        trig = 1'b0;
  logic        run0 = 1'b1;
  logic        c0clk;
  logic        xclk;
  logic [2:0]  outs;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #20 clk = ~clk;

  icm_pin_src #(.HALF(4)) i_src (.i_clk(clk), .i_run0(run0), .o_ctr0_clk(c0clk),
    .o_xtal_clk(xclk));

  icm_timer #(.INT_HALF_CYC(8'h04)) i_dut (
    .i_clk(clk), .i_nrst(nrst), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .i_ctr0_clk(c0clk), .i_first_counter_gate_input(gate),
    .i_external_trigger_input(trig), .i_xtal_clk(xclk),
    .o_ctr0_out(outs[0]), .o_ctr1_out(outs[1]), .o_ctr2_out(outs[2]));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    tick(1);
    wr = 1'b1;
    addr = a;
    wdata = d;
    tick(1);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    tick(1);
    rd = 1'b1;
    addr = a;
    tick(1);
    rd = 1'b0;
    d = rdata;
  endtask

  // cycles until an output reaches a level; a hang ends the run
  task automatic wait_lvl(input int s, input logic l, output int n);
    n = 0;
    while (outs[s] !== l) begin
      tick(1);
      n++;
      if (n > 400) begin
        `CHK("wait", l, outs[s])
        conclude();
      end
    end
  endtask

  task automatic hold(input int s, input logic l, input int k, output int m);
    m = 0;
    repeat (k) begin
      tick(1);
      if (outs[s] !== l) m++;
    end
  endtask

  task automatic t_regs();
    logic [15:0] d;
    `CHK("outs after reset", 3'h7, outs)
    wr_reg(4'h7, 16'hFFFF);
    rd_reg(4'hF, d);
    `CHK("ctrl read", 16'h0000, d)
    rd_reg(4'h7, d);
    `CHK("unmapped read", 16'h0000, d)
    rd_reg(4'h0, d);
    `CHK("count0", 16'h0000, d)
    $display("test regs done");
  endtask

  task automatic t_rate();
    int w;
    int h;
    logic [15:0] a;
    logic [15:0] b;
    wr_reg(4'h3, 16'h0002);
    wr_reg(4'h0, 16'h0004);
    wait_lvl(0, 1'b0, h);
    wait_lvl(0, 1'b1, w);
    `CHK("rate low", 8, w)
    tick(2);
    wr_reg(4'h0, 16'h0006);
    wait_lvl(0, 1'b0, h);
    `CHK("rate period", 32, h + w + 4)
    wait_lvl(0, 1'b1, w);
    wait_lvl(0, 1'b0, h);
    `CHK("new period", 48, h + w)
    gate = 1'b0;
    tick(1);
    `CHK("gate forces high", 1'b1, outs[0])
    rd_reg(4'h0, a);
    tick(40);
    rd_reg(4'h0, b);
    `CHK("held count", a, b)
    gate = 1'b1;
    $display("test rate done");
  endtask

  task automatic t_square();
    int w;
    int h;
    logic [15:0] a;
    logic [15:0] b;
    wr_reg(4'h3, 16'h0003);
    wr_reg(4'h0, 16'h0005);
    wait_lvl(0, 1'b0, h);
    wait_lvl(0, 1'b1, w);
    wait_lvl(0, 1'b0, h);
    `CHK("odd low", 16, w)
    `CHK("odd high", 24, h)
    gate = 1'b0;
    tick(1);
    `CHK("gate forces high", 1'b1, outs[0])
    gate = 1'b1;
    run0 = 1'b0;
    wr_reg(4'hF, 16'h0002);
    wr_reg(4'h3, 16'h0003);
    wr_reg(4'h0, 16'h0002);
    wait_lvl(0, 1'b0, h);
    wait_lvl(0, 1'b1, w);
    wait_lvl(0, 1'b0, h);
    `CHK("div2 low", 8, w)
    `CHK("div2 high", 8, h)
    wr_reg(4'hF, 16'h0000);
    rd_reg(4'h0, a);
    tick(30);
    rd_reg(4'h0, b);
    `CHK("pin clock stopped", a, b)
    run0 = 1'b1;
    $display("test square done");
  endtask

  task automatic t_strobes();
    int t;
    int w;
    int m;
    wr_reg(4'h3, 16'h0004);
    wr_reg(4'h0, 16'h0003);
    wait_lvl(0, 1'b0, t);
    wait_lvl(0, 1'b1, w);
    `CHK("sw delay", 1'b1, (t >= 23 && t <= 34))
    `CHK("sw low", 8, w)
    hold(0, 1'b1, 80, m);
    `CHK("sw single", 0, m)
    wr_reg(4'h0, 16'h0003);
    gate = 1'b0;
    hold(0, 1'b1, 60, m);
    `CHK("sw gate low", 0, m)
    gate = 1'b1;
    wait_lvl(0, 1'b0, t);
    wait_lvl(0, 1'b1, w);
    `CHK("sw resumed low", 8, w)
    gate = 1'b0;
    wr_reg(4'h3, 16'h0005);
    wr_reg(4'h0, 16'h0003);
    hold(0, 1'b1, 40, m);
    `CHK("hw no trigger", 0, m)
    gate = 1'b1;
    tick(2);
    gate = 1'b0;
    tick(8);
    wr_reg(4'h0, 16'h0007);
    wait_lvl(0, 1'b0, t);
    wait_lvl(0, 1'b1, w);
    `CHK("hw delay", 1'b1, (t >= 14 && t <= 21))
    `CHK("hw low", 8, w)
    gate = 1'b1;
    $display("test strobes done");
  endtask

  task automatic t_cascade();
    int t;
    int w;
    int m;
    trig = 1'b0;
    wr_reg(4'hF, 16'h0001);
    wr_reg(4'h3, 16'h0042);
    wr_reg(4'h1, 16'h0002);
    wr_reg(4'h3, 16'h0083);
    wr_reg(4'h2, 16'h0002);
    hold(1, 1'b1, 100, m);
    `CHK("trigger holds pair", 0, m)
    trig = 1'b1;
    wait_lvl(1, 1'b0, t);
    wait_lvl(2, 1'b0, t);
    wait_lvl(2, 1'b1, w);
    wait_lvl(2, 1'b0, t);
    `CHK("cascade low", 16, w)
    `CHK("cascade high", 16, t)
    wr_reg(4'hF, 16'h0000);
    trig = 1'b0;
    wait_lvl(1, 1'b1, t);
    wait_lvl(1, 1'b0, t);
    `CHK("ungated pair low", 1'b1, (t <= 20))
    $display("test cascade done");
  endtask

  task automatic t_pulse();
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] d;
    gate = 1'b0;
    wr_reg(4'hF, 16'h0002);
    wr_reg(4'h3, 16'h0004);
    wr_reg(4'h0, 16'h0000);
    tick(20);
    rd_reg(4'h0, a);
    `CHK("full count", 16'h0000, a)
    gate = 1'b1;
    tick(80);
    gate = 1'b0;
    tick(16);
    rd_reg(4'h0, b);
    d = a - b;
    `CHK("pulse width", 1'b1, (d >= 16'h0009 && d <= 16'h000B))
    $display("test pulse done");
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("Error run expected finish seen timeout");
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_regs();
    t_rate();
    t_square();
    t_strobes();
    t_cascade();
    t_pulse();
    conclude();
  end
endmodule // icm_timer_tb
